// file: inc/bic_defs.svh
// constants for the two-channel input conditioning block
// assumes one 250 MHz clock and an APB master with 32-bit data
//
// Function
// - decode sensor type: off, voltage, current, frequency, PWM, digital, counter
// - analog types take their value from the 12-bit converter
// - digital debounce code: none, 10, 20, 40, 100, 200, 400, 1000 ms
// - frequency and PWM types are routed to the 16-bit timer capture
// - capture filter code rejects glitches under 111 ns, 1.78 us, 14.22 us
// - frequency reported in RPM when pulse-per-rev option set, else hertz
// - digital types report a single bit, 1 on, 0 off
// - pull select bit: 0 pulldown, 1 pullup; pulldown after reset
// - polarity bit: 0 active high, 1 active low; active high after reset
// - normal reads active as 1; inverse reads inactive or open as 1
// - latched: inactive to active gives 1, opposite transition gives 0
// - no fault diagnostics while an input is a digital type
// - result saturated between configured minimum and maximum
// - per-input filter type and constant; no filtering after reset
// - filter 1 is moving average: prev plus difference over constant
// - filter 2 sums N readings, outputs sum over N, then restarts
`ifndef BIC_DEFS_SVH
`define BIC_DEFS_SVH

`define BIC_CLK_NS      4
`define BIC_MS_NS       1000000
`define BIC_GATE_MS     1000
`define BIC_RPM_MUL     60

`define BIC_T_OFF       7'h00
`define BIC_T_V_LO      7'h0c
`define BIC_T_V_HI      7'h0f
`define BIC_T_I_LO      7'h14
`define BIC_T_I_HI      7'h15
`define BIC_T_F_LO      7'h28
`define BIC_T_F_HI      7'h2a
`define BIC_T_P_LO      7'h32
`define BIC_T_P_HI      7'h33
`define BIC_T_D_NORM    7'h3c
`define BIC_T_D_INV     7'h3d
`define BIC_T_D_LATCH   7'h3e
`define BIC_T_C_CNT     7'h46
`define BIC_T_C_PULSE   7'h47
`define BIC_T_C_BOTH    7'h48

`define BIC_FILT1_NS    111
`define BIC_FILT2_NS    1780
`define BIC_FILT3_NS    14220

`define BIC_DEB1_MS     16'h000a
`define BIC_DEB2_MS     16'h0014
`define BIC_DEB3_MS     16'h0028
`define BIC_DEB4_MS     16'h0064
`define BIC_DEB5_MS     16'h00c8
`define BIC_DEB6_MS     16'h0190
`define BIC_DEB7_MS     16'h03e8

`define BIC_OFF_CFG     2'h0
`define BIC_OFF_RANGE   2'h1
`define BIC_OFF_FK      2'h2
`define BIC_OFF_MEAS    2'h3

`define BIC_CFG_RESET   32'h0000_0000
`define BIC_CFG_MASK    32'h0003_777f
`define BIC_MIN_RESET   16'h0000
`define BIC_MAX_RESET   16'hffff
`define BIC_FK_RESET    16'h0001

`endif

// file: inc/bic_pkg.sv
// types shared by the input conditioning block
// assumes bic_defs.svh for the numeric constants
package bic_pkg;

  typedef enum logic [3:0] {
    M_OFF, M_ANALOG, M_FREQ, M_PWM, M_DIG_N, M_DIG_I, M_DIG_L, M_CNT_R, M_CNT_B
  } mode_t;

  // per-channel configuration word, bit 31 at the top
  typedef struct packed {
    logic [13:0] rsvd_hi;
    logic [1:0]  ftype;
    logic        rsvd_b;
    logic        ppr;
    logic        pol;
    logic        pull;
    logic        rsvd_a;
    logic [2:0]  deb;
    logic        rsvd_t;
    logic [6:0]  stype;
  } cfg_t;

endpackage

// file: design/bipolar_input_conditioning.sv
// two-channel sensor input conditioning with APB configuration
// assumes pins are asynchronous, converter results arrive on sys_clk_i
`include "bic_defs.svh"
module bipolar_input_conditioning
  import bic_pkg::*;
#(
  parameter int MS_CYCLES = `BIC_MS_NS / `BIC_CLK_NS,
  parameter int PWM_BITS  = 16
)(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // sensor pins and converter
  input  wire logic [1:0]  pin_i,
  input  wire logic [11:0] adc_data_i [2],
  input  wire logic [1:0]  adc_valid_i,
  // pad control and results
  output logic [1:0]       pull_up_o,
  output logic [1:0]       adc_sel_o,
  output logic [1:0]       timer_sel_o,
  output logic [1:0]       diag_en_o,
  output logic [15:0]      meas_o [2]
);

  localparam int F1_CYC = (`BIC_FILT1_NS + `BIC_CLK_NS - 1) / `BIC_CLK_NS;
  localparam int F2_CYC = (`BIC_FILT2_NS + `BIC_CLK_NS - 1) / `BIC_CLK_NS;
  localparam int F3_CYC = (`BIC_FILT3_NS + `BIC_CLK_NS - 1) / `BIC_CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic mode_t decode(input logic [6:0] t);
    if (t >= `BIC_T_V_LO && t <= `BIC_T_V_HI)      decode = M_ANALOG;
    else if (t >= `BIC_T_I_LO && t <= `BIC_T_I_HI) decode = M_ANALOG;
    else if (t >= `BIC_T_F_LO && t <= `BIC_T_F_HI) decode = M_FREQ;
    else if (t >= `BIC_T_P_LO && t <= `BIC_T_P_HI) decode = M_PWM;
    else if (t == `BIC_T_D_NORM)                   decode = M_DIG_N;
    else if (t == `BIC_T_D_INV)                    decode = M_DIG_I;
    else if (t == `BIC_T_D_LATCH)                  decode = M_DIG_L;
    else if (t == `BIC_T_C_CNT || t == `BIC_T_C_PULSE) decode = M_CNT_R;
    else if (t == `BIC_T_C_BOTH)                   decode = M_CNT_B;
    else                                           decode = M_OFF;
  endfunction

  // restoring divider; slow updates make a wide combinational path tolerable
  function automatic logic [31:0] udiv(input logic [31:0] n, input logic [15:0] d);
    logic [32:0] r;
    logic [31:0] q;
    r = '0;
    q = '0;
    for (int i = 31; i >= 0; i--)
    begin
      r = {r[31:0], n[i]};
      if (r >= {17'h0_0000, d})
      begin
        r = r - {17'h0_0000, d};
        q[i] = 1'b1;
      end
    end
    udiv = q;
  endfunction

  function automatic logic [15:0] sat16(input logic [31:0] v);
    sat16 = (v[31:16] != 16'h0000) ? 16'hffff : v[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and decode

  cfg_t        cfg  [2];
  logic [15:0] rmin [2];
  logic [15:0] rmax [2];
  logic [15:0] fk   [2];
  logic [15:0] meas [2];
  mode_t       mode [2];
  logic [15:0] kk   [2];

  logic acc;
  logic hit;
  logic ch;
  assign acc = psel & penable;
  assign hit = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
  assign ch  = paddr[4];
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;

  always_ff @(posedge sys_clk_i)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (srst_i)
      begin
        cfg[c]  <= `BIC_CFG_RESET;
        rmin[c] <= `BIC_MIN_RESET;
        rmax[c] <= `BIC_MAX_RESET;
        fk[c]   <= `BIC_FK_RESET;
      end
      else if (acc && pwrite && hit && ch == c[0])
      begin
        case (paddr[3:2])
          // reserved bits, bit 11 among them, never store so they read back as zero
          `BIC_OFF_CFG:   cfg[c] <= pwdata & `BIC_CFG_MASK;
          `BIC_OFF_RANGE:
          begin
            rmin[c] <= pwdata[15:0];
            rmax[c] <= pwdata[31:16];
          end
          `BIC_OFF_FK:    fk[c] <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      prdata <= '0;
    else if (psel && !penable && !pwrite && hit)
    begin
      case (paddr[3:2])
        `BIC_OFF_CFG:   prdata <= cfg[ch];
        `BIC_OFF_RANGE: prdata <= {rmax[ch], rmin[ch]};
        `BIC_OFF_FK:    prdata <= {16'h0000, fk[ch]};
        default:        prdata <= {16'h0000, meas[ch]};
      endcase
    end
    else if (psel && !penable)
      prdata <= '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // time base: millisecond tick, one second gate, pwm window

  logic [31:0]         ms_cnt;
  logic [15:0]         gate_cnt;
  logic [PWM_BITS-1:0] pwm_cnt;
  logic ms_tick;
  logic gate_end;
  logic pwm_end;
  assign ms_tick  = (ms_cnt == 32'(MS_CYCLES - 1));
  assign gate_end = ms_tick && (gate_cnt == 16'(`BIC_GATE_MS - 1));
  assign pwm_end  = &pwm_cnt;

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || ms_tick)
      ms_cnt <= '0;
    else
      ms_cnt <= ms_cnt + 32'h1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || gate_end)
      gate_cnt <= '0;
    else if (ms_tick)
      gate_cnt <= gate_cnt + 16'h1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      pwm_cnt <= '0;
    else
      pwm_cnt <= pwm_cnt + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin path: synchroniser, glitch filter or debounce, polarity

  logic [1:0]  s1;
  logic [1:0]  s2;
  logic [1:0]  ql;
  logic [1:0]  act;
  logic [1:0]  act_d;
  logic [1:0]  lat;
  logic [15:0] qcnt [2];
  logic [15:0] thr  [2];
  logic [1:0]  timer;

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      s1 <= '0;
      s2 <= '0;
    end
    else
    begin
      s1 <= pin_i;
      s2 <= s1;
    end
  end

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      mode[c]  = decode(cfg[c].stype);
      timer[c] = (mode[c] == M_FREQ) || (mode[c] == M_PWM);
      kk[c]    = (fk[c] == 16'h0000) ? 16'h0001 : fk[c];
      if (timer[c])
      begin
        case (cfg[c].deb[1:0])
          2'h1:    thr[c] = 16'(F1_CYC);
          2'h2:    thr[c] = 16'(F2_CYC);
          2'h3:    thr[c] = 16'(F3_CYC);
          default: thr[c] = 16'h0000;
        endcase
      end
      else
      begin
        case (cfg[c].deb)
          3'h1:    thr[c] = `BIC_DEB1_MS;
          3'h2:    thr[c] = `BIC_DEB2_MS;
          3'h3:    thr[c] = `BIC_DEB3_MS;
          3'h4:    thr[c] = `BIC_DEB4_MS;
          3'h5:    thr[c] = `BIC_DEB5_MS;
          3'h6:    thr[c] = `BIC_DEB6_MS;
          3'h7:    thr[c] = `BIC_DEB7_MS;
          default: thr[c] = 16'h0000;
        endcase
      end
    end
  end

  // the filter counts clock cycles, the debounce counts millisecond ticks
  always_ff @(posedge sys_clk_i)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (srst_i)
      begin
        ql[c]   <= 1'b0;
        qcnt[c] <= '0;
      end
      else if (s2[c] == ql[c])
        qcnt[c] <= '0;
      else if (thr[c] == 16'h0000)
        ql[c] <= s2[c];
      else if (timer[c] || ms_tick)
      begin
        if (qcnt[c] + 16'h1 >= thr[c])
        begin
          ql[c]   <= s2[c];
          qcnt[c] <= '0;
        end
        else
          qcnt[c] <= qcnt[c] + 16'h1;
      end
    end
  end

  always_comb
  begin
    for (int c = 0; c < 2; c++)
      act[c] = ql[c] ^ cfg[c].pol;
  end

  always_ff @(posedge sys_clk_i)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (srst_i)
      begin
        act_d[c] <= 1'b0;
        lat[c]   <= 1'b0;
      end
      else
      begin
        act_d[c] <= act[c];
        if (act[c] && !act_d[c])
          lat[c] <= 1'b1;
        else if (!act[c] && act_d[c])
          lat[c] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture and counting

  logic [15:0]       ecnt  [2];
  logic [15:0]       hz    [2];
  logic [PWM_BITS:0] hcnt  [2];
  logic [15:0]       duty  [2];
  logic [15:0]       pcnt  [2];

  always_ff @(posedge sys_clk_i)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (srst_i)
      begin
        ecnt[c] <= '0;
        hz[c]   <= '0;
        hcnt[c] <= '0;
        duty[c] <= '0;
        pcnt[c] <= '0;
      end
      else if (mode[c] != M_OFF)
      begin
        if (gate_end)
        begin
          hz[c]   <= ecnt[c];
          ecnt[c] <= '0;
        end
        else if (act[c] && !act_d[c] && ecnt[c] != 16'hffff)
          ecnt[c] <= ecnt[c] + 16'h1;
        if (pwm_end)
        begin
          duty[c] <= 16'(hcnt[c][PWM_BITS:PWM_BITS-10]);
          hcnt[c] <= '0;
        end
        else
          hcnt[c] <= hcnt[c] + {{PWM_BITS{1'b0}}, act[c]};
        if ((mode[c] == M_CNT_R && act[c] && !act_d[c]) ||
            (mode[c] == M_CNT_B && act[c] != act_d[c]))
          pcnt[c] <= pcnt[c] + 16'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // raw selection, filter and saturation

  logic [15:0] raw [2];
  logic [1:0]  stb;
  logic [15:0] avg [2];
  logic [31:0] sum [2];
  logic [15:0] nrd [2];

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      raw[c] = '0;
      stb[c] = ms_tick;
      case (mode[c])
        M_ANALOG:
        begin
          raw[c] = {4'h0, adc_data_i[c]};
          stb[c] = adc_valid_i[c];
        end
        M_FREQ:
        begin
          raw[c] = cfg[c].ppr ? sat16(32'(hz[c]) * `BIC_RPM_MUL) : hz[c];
          stb[c] = gate_end;
        end
        M_PWM:
        begin
          raw[c] = duty[c];
          stb[c] = pwm_end;
        end
        M_DIG_N: raw[c] = {15'h0000, act[c]};
        M_DIG_I: raw[c] = {15'h0000, ~act[c]};
        M_DIG_L: raw[c] = {15'h0000, lat[c]};
        M_CNT_R, M_CNT_B: raw[c] = pcnt[c];
        default: stb[c] = 1'b0;
      endcase
    end
  end

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    if (v < lo)      clamp = lo;
    else if (v > hi) clamp = hi;
    else             clamp = v;
  endfunction

  logic [16:0] dif  [2];
  logic [15:0] step [2];
  logic [31:0] nsum [2];

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      dif[c]  = {1'b0, raw[c]} - {1'b0, avg[c]};
      step[c] = dif[c][16] ? 16'(udiv(32'(16'(-dif[c][15:0])), kk[c]))
                           : 16'(udiv(32'(dif[c][15:0]), kk[c]));
      nsum[c] = sum[c] + 32'(raw[c]);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (srst_i)
      begin
        avg[c]  <= '0;
        sum[c]  <= '0;
        nrd[c]  <= '0;
        meas[c] <= '0;
      end
      else if (mode[c] == M_OFF)
        meas[c] <= '0;
      else if (stb[c])
      begin
        case (cfg[c].ftype)
          2'h1:
          begin
            avg[c]  <= dif[c][16] ? avg[c] - step[c] : avg[c] + step[c];
            meas[c] <= clamp(dif[c][16] ? avg[c] - step[c] : avg[c] + step[c],
                             rmin[c], rmax[c]);
          end
          2'h2:
          begin
            if (nrd[c] + 16'h1 >= kk[c])
            begin
              meas[c] <= clamp(16'(udiv(nsum[c], kk[c])), rmin[c], rmax[c]);
              sum[c]  <= '0;
              nrd[c]  <= '0;
            end
            else
            begin
              sum[c] <= nsum[c];
              nrd[c] <= nrd[c] + 16'h1;
            end
          end
          default: meas[c] <= clamp(raw[c], rmin[c], rmax[c]);
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      meas_o[c]      = meas[c];
      pull_up_o[c]   = cfg[c].pull;
      adc_sel_o[c]   = (mode[c] == M_ANALOG);
      timer_sel_o[c] = timer[c];
      diag_en_o[c]   = (mode[c] == M_ANALOG) || timer[c];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  for (genvar g = 0; g < 2; g++)
  begin : chk
    a_off_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      mode[g] == M_OFF |=> meas[g] == 16'h0000)
      else $error("disabled input did not read zero");
    a_decode_inv: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      cfg[g].stype == `BIC_T_D_INV |-> mode[g] == M_DIG_I && !timer[g])
      else $error("type code decoded wrongly");
    a_diag_digital: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (mode[g] inside {M_DIG_N, M_DIG_I, M_DIG_L}) |-> !diag_en_o[g])
      else $error("diagnostics enabled on digital input");
    a_qual_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $changed(ql[g]) && $past(thr[g]) != 16'h0000 |-> $past(qcnt[g]) + 16'h1 >= $past(thr[g]))
      else $error("level accepted before hold time");
    a_latch_rise: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      act[g] && !act_d[g] |=> lat[g] ##0 (lat[g] throughout (act[g] [*1])) or !act[g])
      else $error("latched state missed rising transition");
    a_adc_value: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      mode[g] == M_ANALOG && adc_valid_i[g] && cfg[g].ftype == 2'h0 &&
      rmin[g] == 16'h0000 && rmax[g] == 16'hffff |=> meas[g] == {4'h0, $past(adc_data_i[g])})
      else $error("converter sample not reported");
    a_dig_bit: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (mode[g] inside {M_DIG_N, M_DIG_I, M_DIG_L}) && stb[g] && cfg[g].ftype == 2'h0 &&
      rmin[g] == 16'h0000 |=> meas[g] <= 16'h0001)
      else $error("digital result wider than one bit");
    a_clamp_range: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      mode[g] != M_OFF && stb[g] && cfg[g].ftype == 2'h0 && rmin[g] <= rmax[g] &&
      !(psel && pwrite) |=> meas[g] >= rmin[g] && meas[g] <= rmax[g])
      else $error("result outside configured range");
    a_rpm_scale: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      mode[g] == M_FREQ && cfg[g].ppr && hz[g] < 16'h0400 |-> raw[g] == hz[g] * 16'(`BIC_RPM_MUL))
      else $error("rpm scaling wrong");
    a_pull_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      acc && pwrite && hit && ch == g[0] && paddr[3:2] == `BIC_OFF_CFG
      |=> pull_up_o[g] == $past(pwdata[12]))
      else $error("pull select not applied");
  end

endmodule

// file: dv/sensor_stub.sv
// far-side model: two sensor lines with pull resolution and a converter
// assumes the bench sets mode and values by non-blocking assignment
module sensor_stub (
  // clock
  input  wire logic        sys_clk_i,
  // control from the bench, two bits a channel: open, low, high, toggle
  input  wire logic [3:0]  mode_i,
  input  wire logic [7:0]  half_i,
  input  wire logic [11:0] adc_val_i,
  input  wire logic [1:0]  adc_go_i,
  input  wire logic [1:0]  pull_up_i,
  // toward the block
  output logic [1:0]       pin_o,
  output logic [11:0]      adc_data_o [2],
  output logic [1:0]       adc_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt [2];
  logic [1:0] tog;

  initial cnt = '{8'h00, 8'h00};
  initial tog = 2'h0;

  always @(posedge sys_clk_i)
  begin
    for (int c = 0; c < 2; c++)
    begin
      cnt[c] <= (cnt[c] + 8'h01 >= half_i) ? 8'h00 : cnt[c] + 8'h01;
      if (cnt[c] + 8'h01 >= half_i)
        tog[c] <= ~tog[c];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // an open line settles to whichever resistor the block selects
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      case (mode_i[2*c +: 2])
        2'h0:    pin_o[c] = pull_up_i[c];
        2'h1:    pin_o[c] = 1'b0;
        2'h2:    pin_o[c] = 1'b1;
        default: pin_o[c] = tog[c];
      endcase
      // stale converter data is inverted so it can never pass for a result
      adc_data_o[c] = adc_go_i[c] ? adc_val_i : ~adc_val_i;
    end
  end

  assign adc_valid_o = adc_go_i;
endmodule

// file: dv/tb_top.sv
// self-checking bench for the two-channel input conditioning block
// assumes a 250 MHz clock; the millisecond tick is shortened to 10 cycles
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bic_pkg::*;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pin;
  logic [11:0] adc_data [2];
  logic [1:0]  adc_valid;
  logic [1:0]  pull_up;
  logic [1:0]  adc_sel;
  logic [1:0]  timer_sel;
  logic [1:0]  diag_en;
  logic [15:0] meas [2];
  logic [3:0]  mode = 4'h0;
  logic [7:0]  half = 8'h0a;
  logic [11:0] adc_val = 12'h000;
  logic [1:0]  adc_go = 2'h0;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  always #2 clk = ~clk;

  bipolar_input_conditioning #(.MS_CYCLES(10), .PWM_BITS(11)) u_bipolar_input_conditioning (
    .sys_clk_i(clk), .srst_i(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_i(pin), .adc_data_i(adc_data), .adc_valid_i(adc_valid), .pull_up_o(pull_up),
    .adc_sel_o(adc_sel), .timer_sel_o(timer_sel), .diag_en_o(diag_en), .meas_o(meas));

  sensor_stub u_sensor_stub (
    .sys_clk_i(clk), .mode_i(mode), .half_i(half), .adc_val_i(adc_val), .adc_go_i(adc_go),
    .pull_up_i(pull_up), .pin_o(pin), .adc_data_o(adc_data), .adc_valid_o(adc_valid));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // the whole run needs about 67500 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask

  function automatic logic [31:0] mk(logic [6:0] st, logic [2:0] deb, logic pl,
                                     logic pol, logic ppr, logic [1:0] ft);
    cfg_t c;
    c = '0;
    c.stype = st;
    c.deb = deb;
    c.pull = pl;
    c.pol = pol;
    c.ppr = ppr;
    c.ftype = ft;
    return c;
  endfunction

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    mode <= 4'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic adc(input int ch, input logic [11:0] v);
    @(posedge clk);
    adc_val <= v;
    adc_go <= 2'h1 << ch;
    @(posedge clk);
    adc_go <= 2'h0;
    repeat (4) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk(8'h00, 32'h0, 1'b0);
    rd_chk(8'h14, 32'hffff_0000, 1'b0);
    rd_chk(8'h18, 32'h0000_0001, 1'b0);
    rd_chk(8'h0c, 32'h0, 1'b0);
    `CHK(pull_up, 2'h0)
    rd_chk(8'h20, 32'h0, 1'b1);
    wr(8'h10, 32'hffff_ffff);
    rd_chk(8'h10, 32'h0003_777f, 1'b0);
    `CHK(pull_up, 2'h2)
  endtask

  task automatic t_types();
    logic [6:0] codes [19] = '{7'd0, 7'd12, 7'd13, 7'd14, 7'd15, 7'd20, 7'd21, 7'd40,
      7'd41, 7'd42, 7'd50, 7'd51, 7'd60, 7'd61, 7'd62, 7'd70, 7'd71, 7'd72, 7'd16};
    logic an;
    logic tm;
    do_reset();
    foreach (codes[i])
    begin
      an = codes[i] inside {[7'd12:7'd15], 7'd20, 7'd21};
      tm = codes[i] inside {[7'd40:7'd42], 7'd50, 7'd51};
      wr(8'h00, mk(codes[i], 3'h0, 1'b0, 1'b0, 1'b0, 2'h0));
      @(posedge clk);
      `CHK(adc_sel[0], an)
      `CHK(timer_sel[0], tm)
      `CHK(diag_en[0], an | tm)
    end
  endtask

  task automatic t_analog();
    wr(8'h10, mk(7'd13, 3'h0, 1'b0, 1'b0, 1'b0, 2'h0));
    adc(1, 12'h5a3);
    `CHK(meas[1], 16'h05a3)
    rd_chk(8'h1c, 32'h0000_05a3, 1'b0);
    wr(8'h14, 32'h0200_0100);
    adc(1, 12'hfff);
    `CHK(meas[1], 16'h0200)
    adc(1, 12'h010);
    `CHK(meas[1], 16'h0100)
    wr(8'h10, 32'h0);
    // mode goes off on the write edge itself, the zero lands one edge later
    repeat (2) @(posedge clk);
    `CHK(meas[1], 16'h0000)
    adc(1, 12'h300);
    `CHK(meas[1], 16'h0000)
  endtask

  task automatic t_filt();
    do_reset();
    wr(8'h08, 32'h4);
    wr(8'h00, mk(7'd12, 3'h0, 1'b0, 1'b0, 1'b0, 2'h1));
    adc(0, 12'h100);
    `CHK(meas[0], 16'h0040)
    adc(0, 12'h100);
    `CHK(meas[0], 16'h0070)
    do_reset();
    wr(8'h08, 32'h3);
    wr(8'h00, mk(7'd12, 3'h0, 1'b0, 1'b0, 1'b0, 2'h2));
    adc(0, 12'h003);
    adc(0, 12'h006);
    `CHK(meas[0], 16'h0000)
    adc(0, 12'h009);
    `CHK(meas[0], 16'h0006)
    adc(0, 12'h000);
    adc(0, 12'h000);
    adc(0, 12'h003);
    `CHK(meas[0], 16'h0001)
  endtask

  task automatic t_dig();
    do_reset();
    wr(8'h00, mk(7'd60, 3'h1, 1'b0, 1'b0, 1'b0, 2'h0));
    mode <= 4'h2;
    repeat (40) @(posedge clk);
    `CHK(meas[0], 16'h0000)
    repeat (160) @(posedge clk);
    `CHK(meas[0], 16'h0001)
    mode <= 4'h0;
    repeat (200) @(posedge clk);
    `CHK(meas[0], 16'h0000)
    wr(8'h00, mk(7'd60, 3'h0, 1'b0, 1'b1, 1'b0, 2'h0));
    mode <= 4'h1;
    repeat (30) @(posedge clk);
    `CHK(meas[0], 16'h0001)
    wr(8'h00, mk(7'd61, 3'h0, 1'b0, 1'b0, 1'b0, 2'h0));
    mode <= 4'h0;
    repeat (30) @(posedge clk);
    `CHK(meas[0], 16'h0001)
    mode <= 4'h2;
    repeat (30) @(posedge clk);
    `CHK(meas[0], 16'h0000)
    wr(8'h00, mk(7'd62, 3'h0, 1'b1, 1'b0, 1'b0, 2'h0));
    @(posedge clk);
    `CHK(pull_up[0], 1'b1)
    mode <= 4'h1;
    repeat (30) @(posedge clk);
    mode <= 4'h2;
    repeat (30) @(posedge clk);
    `CHK(meas[0], 16'h0001)
    mode <= 4'h1;
    repeat (30) @(posedge clk);
    `CHK(meas[0], 16'h0000)
  endtask

  // both lines toggle with a 20-cycle period: ch0 as pwm at half duty, ch1 counts both edges;
  // the third 2048-cycle window reports the second window's duty, 510 to 513 of 1024
  task automatic t_pwm_cnt();
    do_reset();
    mode <= 4'hf;
    wr(8'h10, mk(7'd72, 3'h0, 1'b0, 1'b0, 1'b0, 2'h0));
    wr(8'h00, mk(7'd50, 3'h0, 1'b0, 1'b0, 1'b0, 2'h0));
    repeat (6200) @(posedge clk);
    `CHK(meas[0] >= 16'd510 && meas[0] <= 16'd513, 1'b1)
    `CHK(meas[1] >= 16'd615 && meas[1] <= 16'd623, 1'b1)
    wr(8'h00, mk(7'd70, 3'h0, 1'b0, 1'b0, 1'b0, 2'h0));
    repeat (400) @(posedge clk);
    `CHK(meas[0] >= 16'd17 && meas[0] <= 16'd21, 1'b1)
  endtask

  // toggling every 10 cycles gives 500 rising edges in a 10000-cycle gate
  task automatic t_freq(input logic [2:0] flt, input logic ppr, input int lo, input int hi);
    do_reset();
    mode <= 4'h3;
    wr(8'h00, mk(7'd40, flt, 1'b0, 1'b0, ppr, 2'h0));
    repeat (20010) @(posedge clk);
    `CHK(int'(meas[0]) >= lo && int'(meas[0]) <= hi, 1'b1)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    t_regs();
    t_types();
    t_analog();
    t_filt();
    t_dig();
    t_pwm_cnt();
    t_freq(3'h0, 1'b0, 499, 501);
    t_freq(3'h0, 1'b1, 29940, 30060);
    t_freq(3'h1, 1'b0, 0, 0);
    tally_and_finish();
  end
endmodule
